// file: sim/tef_flags_monitor.sv
// Port-level checks of the timer event flag block
`timescale 1ns/1ps
module tef_flags_monitor (
    input logic clk,
    input logic rst,
    input logic center_align_select,
    input logic [15:0] modulus,
    input logic counter_write,
    input logic [15:0] counter_value,
    input logic overflow_irq_enable,
    input logic counter_overflow_flag,
    input logic overflow_irq,
    input logic [1:0] channel_mode_high_bit,
    input logic [1:0] channel_mode_low_bit,
    input logic [31:0] channel_value,
    input logic [1:0] channel_irq_enable,
    input logic [1:0] channel_flag_write_zero,
    input logic [1:0] channel_event_flag,
    input logic [1:0] channel_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Counter writes suppress events, so those cycles are skipped
    logic up;
    logic ud;
    assign up = !center_align_select && !counter_write;
    assign ud = center_align_select && !counter_write;

    a_irq_level:
        assert property (overflow_irq == (overflow_irq_enable && counter_overflow_flag)
            && channel_irq == (channel_irq_enable & channel_event_flag)) else $error("Bad level");
    a_reset_clears:
        assert property ($past(rst) |-> !counter_overflow_flag && channel_event_flag == 2'h0
            && !overflow_irq_enable && channel_irq_enable == 2'h0) else $error("Reset left state");
    a_wrap_free:
        assert property (up && modulus == 16'h0000 && counter_value == 16'hffff
            |=> counter_overflow_flag && counter_value == 16'h0000) else $error("No top wrap");
    a_wrap_modulus:
        assert property (up && modulus != 16'h0000 && counter_value == modulus
            |=> counter_overflow_flag && counter_value == 16'h0000) else $error("No mod wrap");
    a_turn_down:
        assert property (ud && modulus != 16'h0000 && counter_value == modulus
            && $past(counter_value) + 16'h0001 == counter_value && !$past(counter_write)
            |=> counter_overflow_flag && counter_value == modulus - 16'h0001) else $error("No turn");
    a_compare_match:
        assert property (up && !channel_mode_high_bit[0] && channel_mode_low_bit[0]
            && counter_value == channel_value[15:0] |=> channel_event_flag[0]) else $error("No match");
    a_flag_holds:
        assert property (channel_event_flag[0] && !channel_flag_write_zero[0]
            |=> channel_event_flag[0]) else $error("Flag lost");
    a_clear_cause:
        assert property ($fell(channel_event_flag[0]) && !$past(rst)
            |-> $past(channel_flag_write_zero[0])) else $error("Clear without write");
endmodule

bind tef_timer_event_flags tef_flags_monitor u_mon (.clk, .rst, .center_align_select, .modulus,
    .counter_write, .counter_value, .overflow_irq_enable, .counter_overflow_flag, .overflow_irq,
    .channel_mode_high_bit, .channel_mode_low_bit, .channel_value, .channel_irq_enable,
    .channel_flag_write_zero, .channel_event_flag, .channel_irq);

// file: sim/testbench.sv
// Self-checking bench for the timer event flag block
`timescale 1ns/1ps
module testbench;
    // Stimulus, idle at time zero
    logic clk = 1'b0, rst = 1'b1, ca = 1'b0, cw = 1'b0, ord = 1'b0, owz = 1'b0;
    logic oe_wr = 1'b0, oe_in = 1'b0, crd = 1'b0;
    logic [15:0] modv = 16'h0000;
    logic [31:0] cval = 32'h0000_0002;
    logic [1:0] mhi = 2'h0, mlo = 2'h0, ehi = 2'h0, elo = 2'h0, pin = 2'h0;
    logic [1:0] ie_wr = 2'h0, ie_in = 2'h0, frd = 2'h0, fwz = 2'h0;
    // Observed outputs
    logic [15:0] cnt, lat;
    logic oen, oflag, oirq;
    logic [1:0] cie, cflag, cirq;
    int n_fail = 0;
    int tests_run = 0;

    always #50 clk = ~clk;

    tef_timer_event_flags uut (.clk(clk), .rst(rst), .center_align_select(ca), .modulus(modv),
        .counter_write(cw), .counter_read(crd), .counter_value(cnt), .counter_read_latch(lat),
        .overflow_irq_enable_wr(oe_wr), .overflow_irq_enable_in(oe_in), .overflow_irq_enable(oen),
        .overflow_flag_read(ord), .overflow_flag_write_zero(owz), .counter_overflow_flag(oflag),
        .overflow_irq(oirq), .channel_mode_high_bit(mhi), .channel_mode_low_bit(mlo),
        .edge_select_high_bit(ehi), .edge_select_low_bit(elo), .channel_value(cval),
        .channel_pin(pin), .channel_irq_enable_wr(ie_wr), .channel_irq_enable_in(ie_in),
        .channel_irq_enable(cie), .channel_flag_read(frd), .channel_flag_write_zero(fwz),
        .channel_event_flag(cflag), .channel_irq(cirq));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask

    task end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Edges, then settle so sampled outputs are stable
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Optional read, then write zero; rd low tests a bare write
    task clr(input logic ov, input logic rd);
        @(posedge clk) ord <= ov & rd;
        frd <= {1'b0, !ov && rd};
        @(posedge clk) ord <= 1'b0;
        frd <= 2'h0;
        owz <= ov;
        fwz <= {1'b0, !ov};
        @(posedge clk) owz <= 1'b0;
        fwz <= 2'h0;
        #1;
    endtask

    // Bounded wait on the overflow or channel 0 flag
    task wait_ev(input logic ov, input int lim);
        int i;
        for (i = 0; i < lim && (ov ? oflag : cflag[0]) !== 1'b1; i++)
            tick(1);
        if (i == lim)
        begin
            n_fail++;
            $display("ERROR at %0t: flag wait ran out", $time);
            end_of_test;
        end
    endtask

    task cwrite;
        @(posedge clk) cw <= 1'b1;
        @(posedge clk) cw <= 1'b0;
        #1;
    endtask

    // One byte read of the counter, a single-cycle strobe
    task rd_cnt;
        @(posedge clk) crd <= 1'b1;
        @(posedge clk) crd <= 1'b0;
        #1;
    endtask

    task t_overflow;
        chk({oflag, cflag, oen, cie, oirq, cirq}, 16'h0000);
        cwrite;
        wait_ev(1'b1, 70000);
        chk(cnt, 16'h0000);
        @(posedge clk) oe_wr <= 1'b1;
        oe_in <= 1'b1;
        @(posedge clk) oe_wr <= 1'b0;
        #1;
        chk(oirq, 1'b1);
        clr(1'b1, 1'b0);
        chk(oflag, 1'b1);
        chk(oirq, 1'b1);
        clr(1'b1, 1'b1);
        chk({oflag, oirq}, 16'h0000);
        @(posedge clk) modv <= 16'h0005;
        cwrite;
        wait_ev(1'b1, 20);
        chk(cnt, 16'h0000);
        $display("overflow test done");
    endtask

    // Centre mode: two channel matches per period, overflow at the turn
    task t_updown;
        @(posedge clk) ca <= 1'b1;
        modv <= 16'h0008;
        cwrite;
        wait_ev(1'b0, 30);
        chk(cnt, 16'h0003);
        clr(1'b0, 1'b1);
        wait_ev(1'b0, 30);
        chk(cnt, 16'h0001);
        clr(1'b1, 1'b1);
        wait_ev(1'b1, 30);
        chk(cnt, 16'h0007);
        // Channel 1 matched at zero; its own flag, its request still masked
        chk({cflag[1], cirq[1]}, 16'h0002);
        clr(1'b0, 1'b1);
        $display("up/down test done");
    endtask

    task t_compare;
        @(posedge clk) ca <= 1'b0;
        modv <= 16'h0010;
        mlo <= 2'h1;
        cval <= 32'h0000_0007;
        cwrite;
        wait_ev(1'b0, 40);
        chk(cnt, 16'h0008);
        clr(1'b0, 1'b1);
        @(posedge clk) cval <= 32'h0000_0009;
        @(posedge clk) mhi <= 2'h1;
        mlo <= 2'h0;
        cwrite;
        wait_ev(1'b0, 40);
        chk(cnt, 16'h000a);
        @(posedge clk) mhi <= 2'h0;
        clr(1'b0, 1'b1);
        chk(cflag[0], 1'b0);
        $display("compare test done");
    endtask

    // Every edge-select code with a rising and a falling pin edge
    task t_capture;
        @(posedge clk) ie_wr <= 2'h1;
        ie_in <= 2'h1;
        @(posedge clk) ie_wr <= 2'h0;
        for (int code = 0; code < 4; code++)
        begin
            @(posedge clk) {ehi[0], elo[0]} <= code[1:0];
            pin <= 2'h1;
            tick(5);
            chk(cflag[0], code[0]);
            chk(cirq[0], code[0]);
            clr(1'b0, 1'b1);
            @(posedge clk) pin <= 2'h0;
            tick(5);
            chk(cflag[0], code[1]);
            clr(1'b0, 1'b1);
        end
        @(posedge clk) pin <= 2'h1;
        tick(5);
        @(posedge clk) frd <= 2'h1;
        pin <= 2'h0;
        @(posedge clk) frd <= 2'h0;
        tick(5);
        @(posedge clk) fwz <= 2'h1;
        @(posedge clk) fwz <= 2'h0;
        #1;
        chk(cflag[0], 1'b1);
        clr(1'b0, 1'b1);
        chk(cflag[0], 1'b0);
        $display("capture test done");
    endtask

    // Coherent read: first read freezes, second frees, counter write rearms
    task t_latch;
        cwrite;
        rd_cnt;
        chk(lat, 16'h0001);
        rd_cnt;
        chk(lat, 16'h0001);
        rd_cnt;
        chk(lat, 16'h0005);
        // Latch left full here; the write must empty it
        cwrite;
        chk(lat, 16'h0000);
        chk(cnt, 16'h0000);
        rd_cnt;
        chk(lat, 16'h0001);
        $display("latch test done");
    endtask

    initial
    begin
        tick(11);
        @(posedge clk) rst <= 1'b0;
        #1;
        t_overflow;
        t_updown;
        t_compare;
        t_capture;
        t_latch;
        end_of_test;
    end
endmodule

// file: src/tef_pkg.sv
// Package with constants and types for the timer event flag block
package tef_pkg;
    // Channel count of the timer
    localparam int NUM_CH = 2;
    // Counter width
    localparam int CNT_W = 16;
    // Counter value after reset and on wrap
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // Top of a free-running count
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Count step
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Flag and enable values after reset
    localparam logic FLAG_RESET = 1'b0;
    // Edge select codes (high bit, low bit)
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_ANY = 2'h3;
    // Channel mode codes when centre-align select is 0
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    // Codes 2 and 3 both select edge-aligned PWM
    localparam int MODE_PWM_BIT = 1;
endpackage

// file: src/tef_timer_event_flags.sv
// Counter, per-channel event detection and two-step clearable event flags
`timescale 1ns/1ps

// Summary of operation
// - Overflow flag plus one flag per channel.
// - Capture mode: selected edge sets channel flag.
// - Compare mode: counter equals value sets flag.
// - Flags pollable; enable and flag drive request.
// - Clear needs read-while-set then write zero.
// - Event between read and write aborts clear.
// - Free-run counts 0000 to FFFF then wraps.
// - With modulus, overflow at modulus-to-zero wrap.
// - Up/down: overflow when turning down at modulus.
// - Two-bit edge select: rise, fall, both, off.
// - Edge PWM: match at duty end sets flag.
// - Centre PWM: both matches per cycle set flag.
// - Mode bits pick capture, compare, edge PWM.
// - Centre-align counts up to modulus, down.
// - Counter write resets counter and read latch.
module tef_timer_event_flags (
    input wire logic clk,
    input wire logic rst,
    input wire logic center_align_select,
    input wire logic [15:0] modulus,
    input wire logic counter_write,
    input wire logic counter_read,
    output logic [15:0] counter_value,
    output logic [15:0] counter_read_latch,
    input wire logic overflow_irq_enable_wr,
    input wire logic overflow_irq_enable_in,
    output logic overflow_irq_enable,
    input wire logic overflow_flag_read,
    input wire logic overflow_flag_write_zero,
    output logic counter_overflow_flag,
    output logic overflow_irq,
    input wire logic [1:0] channel_mode_high_bit,
    input wire logic [1:0] channel_mode_low_bit,
    input wire logic [1:0] edge_select_high_bit,
    input wire logic [1:0] edge_select_low_bit,
    input wire logic [31:0] channel_value,
    input wire logic [1:0] channel_pin,
    input wire logic [1:0] channel_irq_enable_wr,
    input wire logic [1:0] channel_irq_enable_in,
    output logic [1:0] channel_irq_enable,
    input wire logic [1:0] channel_flag_read,
    input wire logic [1:0] channel_flag_write_zero,
    output logic [1:0] channel_event_flag,
    output logic [1:0] channel_irq
);

    // Counter direction; high while counting down in centre-aligned mode
    logic count_down;
    // Overflow event this cycle
    logic overflow_event;
    // Per-channel event this cycle
    logic [1:0] channel_event;
    // Clear sequence armed: read seen while the flag was set
    logic overflow_armed;
    logic [1:0] channel_armed;
    // Read latch holds until the second byte read
    logic latch_full;
    // Pin synchronisers and previous synchronised level
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_prev;
    // Terminal value of the up count
    logic [15:0] count_top;

    // Zero modulus means free running to the full count
    assign count_top = (modulus == tef_pkg::CNT_RESET) ? tef_pkg::CNT_MAX : modulus;

    // Overflow event for both counting modes
    always_comb
    begin
        if (counter_write)
        begin
            overflow_event = 1'b0; // A manual reset is not an overflow
        end
        else if (center_align_select)
        begin
            // Turnaround at modulus toward the next lower count
            overflow_event = !count_down && (counter_value == modulus);
        end
        else
        begin
            // Wrap from top to zero
            overflow_event = (counter_value == count_top);
        end
    end

    // Main counter and direction
    always_ff @(posedge clk)
    begin
        if (rst || counter_write)
        begin
            counter_value <= tef_pkg::CNT_RESET;
            count_down <= 1'b0;
        end
        else if (center_align_select)
        begin
            // Up to modulus, then down to zero, period twice modulus
            if (!count_down && counter_value == modulus)
            begin
                count_down <= 1'b1;
                counter_value <= counter_value - tef_pkg::CNT_ONE;
            end
            else if (count_down && counter_value == tef_pkg::CNT_RESET)
            begin
                count_down <= 1'b0;
                counter_value <= counter_value + tef_pkg::CNT_ONE;
            end
            else if (count_down)
            begin
                counter_value <= counter_value - tef_pkg::CNT_ONE;
            end
            else
            begin
                counter_value <= counter_value + tef_pkg::CNT_ONE;
            end
        end
        else
        begin
            count_down <= 1'b0;
            if (counter_value == count_top)
            begin
                counter_value <= tef_pkg::CNT_RESET;
            end
            else
            begin
                counter_value <= counter_value + tef_pkg::CNT_ONE;
            end
        end
    end

    // Coherent read latch; frozen until the second read
    always_ff @(posedge clk)
    begin
        if (rst || counter_write)
        begin
            counter_read_latch <= tef_pkg::CNT_RESET;
            latch_full <= 1'b0;
        end
        else if (counter_read && !latch_full)
        begin
            counter_read_latch <= counter_value; // First byte captures both
            latch_full <= 1'b1;
        end
        else if (counter_read)
        begin
            latch_full <= 1'b0; // Second byte releases the latch
        end
    end

    // Two-flop synchroniser on the channel pins, then edge history
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_prev <= 2'h0;
        end
        else
        begin
            pin_meta <= channel_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Channel event decode by mode
    always_comb
    begin
        for (int i = 0; i < tef_pkg::NUM_CH; i++)
        begin
            logic rise;
            logic fall;
            logic match;
            rise = pin_sync[i] && !pin_prev[i];
            fall = !pin_sync[i] && pin_prev[i];
            match = (counter_value == channel_value[i*16 +: 16]);
            channel_event[i] = 1'b0;
            if (counter_write)
            begin
                channel_event[i] = 1'b0; // Counter reset this cycle
            end
            else if (center_align_select)
            begin
                // Match while counting up and while counting down
                channel_event[i] = match;
            end
            else if (channel_mode_high_bit[i])
            begin
                channel_event[i] = match;
            end
            else if (channel_mode_low_bit[i])
            begin
                channel_event[i] = match;
            end
            else
            begin
                // Capture with edge select; off disables the trigger
                unique case ({edge_select_high_bit[i], edge_select_low_bit[i]})
                    tef_pkg::EDGE_OFF: channel_event[i] = 1'b0;
                    tef_pkg::EDGE_RISE: channel_event[i] = rise;
                    tef_pkg::EDGE_FALL: channel_event[i] = fall;
                    tef_pkg::EDGE_ANY: channel_event[i] = rise || fall;
                endcase
            end
        end
    end

    // Interrupt enables
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            overflow_irq_enable <= tef_pkg::FLAG_RESET;
            channel_irq_enable <= 2'h0;
        end
        else
        begin
            if (overflow_irq_enable_wr)
            begin
                overflow_irq_enable <= overflow_irq_enable_in;
            end
            for (int i = 0; i < tef_pkg::NUM_CH; i++)
            begin
                if (channel_irq_enable_wr[i])
                begin
                    channel_irq_enable[i] <= channel_irq_enable_in[i];
                end
            end
        end
    end

    // Overflow flag with two-step clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            counter_overflow_flag <= tef_pkg::FLAG_RESET;
            overflow_armed <= 1'b0;
        end
        else if (overflow_event)
        begin
            // New event sets flag and drops any pending clear
            counter_overflow_flag <= 1'b1;
            overflow_armed <= 1'b0;
        end
        else if (overflow_flag_write_zero)
        begin
            if (overflow_armed)
            begin
                counter_overflow_flag <= 1'b0;
            end
            overflow_armed <= 1'b0;
        end
        else if (overflow_flag_read && counter_overflow_flag)
        begin
            overflow_armed <= 1'b1;
        end
    end

    // Channel flags with two-step clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            channel_event_flag <= 2'h0;
            channel_armed <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < tef_pkg::NUM_CH; i++)
            begin
                if (channel_event[i])
                begin
                    channel_event_flag[i] <= 1'b1;
                    channel_armed[i] <= 1'b0;
                end
                else if (channel_flag_write_zero[i])
                begin
                    if (channel_armed[i])
                    begin
                        channel_event_flag[i] <= 1'b0;
                    end
                    channel_armed[i] <= 1'b0;
                end
                else if (channel_flag_read[i] && channel_event_flag[i])
                begin
                    channel_armed[i] <= 1'b1;
                end
            end
        end
    end

    // Static level requests; stay up until software clears the flag
    assign overflow_irq = overflow_irq_enable && counter_overflow_flag;
    assign channel_irq = channel_irq_enable & channel_event_flag;

endmodule
